// ---- pwm16_pkg.sv ----
/*
 * Constants for the 16-bit dual-slope PWM timer: mode codes, fixed tops,
 * prescale factors and reset values.
 * Assumes a single 50 MHz clock and a synchronous active-high reset.
 */
// Summary of operation
// - Modes 1,2,3,10,11 count up then down
// - Modes 1,2,3 turn at 0x00FF/0x01FF/0x03FF
// - Mode 10 top capture, 11 compare A
// - Modes 8,9 frequency correct, tops capture/A
// - Both families use dual-slope counting
// - Counter holds top for one tick
// - Non-inverting: clear up-match, set down-match
// - Output code 2 normal, 3 inverted
// - Compare flag set when count equals compare
// - Phase correct: overflow flag at bottom
// - Phase correct: load at top, top flag
// - Frequency correct: load and overflow at bottom
// - Frequency correct: top flag when reaching top
// - Variable top from 0x0003 to 0xFFFF
// - Fixed top masks compare writes to resolution
// - Phase correct: compare 0 low, top high
// - Frequency correct: compare 0 low, top high
// - Pin driven only when direction is output
// - Period is 2 x prescale x top
// - Output code 0 disconnects compare output
// - Code 1 toggles A if top bit
package pwm16_pkg;

    localparam int COUNT_W = 16;
    localparam int CLK_PERIOD_NS = 20;

    localparam logic [3:0] WAVE_PC8 = 4'h1;
    localparam logic [3:0] WAVE_PC9 = 4'h2;
    localparam logic [3:0] WAVE_PC10 = 4'h3;
    localparam logic [3:0] WAVE_PFC_CAP = 4'h8;
    localparam logic [3:0] WAVE_PFC_CMPA = 4'h9;
    localparam logic [3:0] WAVE_PC_CAP = 4'hA;
    localparam logic [3:0] WAVE_PC_CMPA = 4'hB;
    localparam int WAVE_TOP_BIT = 3;

    localparam logic [15:0] TOP_8BIT = 16'h00FF;
    localparam logic [15:0] TOP_9BIT = 16'h01FF;
    localparam logic [15:0] TOP_10BIT = 16'h03FF;
    localparam logic [15:0] TOP_MIN_VARIABLE = 16'h0003;

    localparam logic [1:0] OUT_DISCONNECT = 2'h0;
    localparam logic [1:0] OUT_TOGGLE = 2'h1;
    localparam logic [1:0] OUT_NORMAL = 2'h2;
    localparam logic [1:0] OUT_INVERTED = 2'h3;

    localparam logic [2:0] PRESCALE_STOP = 3'h0;
    localparam logic [2:0] PRESCALE_SEL_1 = 3'h1;
    localparam logic [2:0] PRESCALE_SEL_8 = 3'h2;
    localparam logic [2:0] PRESCALE_SEL_64 = 3'h3;
    localparam logic [2:0] PRESCALE_SEL_256 = 3'h4;
    localparam logic [2:0] PRESCALE_SEL_1024 = 3'h5;
    localparam int PRESCALE_W = 10;
    localparam logic [9:0] DIV_1 = 10'h000;
    localparam logic [9:0] DIV_8 = 10'h007;
    localparam logic [9:0] DIV_64 = 10'h03F;
    localparam logic [9:0] DIV_256 = 10'h0FF;
    localparam logic [9:0] DIV_1024 = 10'h3FF;

    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COMPARE_RESET = 16'h0000;

endpackage

// ---- compare_channel.sv ----
/*
 * One compare channel: double-buffered compare value, match detect and
 * the waveform level it drives.
 * Assumes the parent supplies the tick, direction, top and update strobe.
 */
`timescale 1ns/1ps
`default_nettype none
module compare_channel
    import pwm16_pkg::*;
#(
    parameter bit CAN_TOGGLE = 1'b0
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic tick_i,
    input wire logic wr_i,
    input wire logic [COUNT_W-1:0] wdata_i,
    input wire logic load_i,
    input wire logic [COUNT_W-1:0] count_i,
    input wire logic dir_up_i,
    input wire logic [COUNT_W-1:0] top_i,
    input wire logic [1:0] mode_i,
    input wire logic wave_top_bit_i,
    output logic match_o,
    output logic [COUNT_W-1:0] active_o,
    output logic wave_o
);
    logic [COUNT_W-1:0] buffer_q;
    logic wave_q;
    logic level_d;

    // -----------------------------------------------------------------
    // Buffer and active compare value
    // -----------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            buffer_q <= COMPARE_RESET;
        end else if (wr_i) begin
            buffer_q <= wdata_i;
        end
    end

    // Software may write in the load cycle: the fresh value goes live
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            active_o <= COMPARE_RESET;
        end else if (load_i) begin
            active_o <= wr_i ? wdata_i : buffer_q;
        end
    end

    assign match_o = tick_i && (count_i == active_o);

    // -----------------------------------------------------------------
    // Waveform level
    // -----------------------------------------------------------------
    always_comb begin
        if (active_o == top_i) begin
            level_d = 1'b1;
        end else if (active_o == COMPARE_RESET) begin
            level_d = 1'b0;
        end else begin
            level_d = ~dir_up_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            wave_q <= 1'b0;
        end else if (match_o) begin
            case (mode_i)
                OUT_NORMAL: wave_q <= level_d;
                OUT_INVERTED: wave_q <= ~level_d;
                OUT_TOGGLE: begin
                    if (CAN_TOGGLE && wave_top_bit_i) begin
                        wave_q <= ~wave_q;
                    end
                end
                default: wave_q <= wave_q;
            endcase
        end
    end

    assign wave_o = wave_q;
endmodule
`default_nettype wire

// ---- dual_slope_pwm_timer16.sv ----
/*
 * Dual-slope 16-bit PWM timer: prescaler, up/down counter, top select,
 * two compare channels, event flags and pin muxing.
 * Assumes control bits are steady plain inputs and pins are resolved
 * outside from value and output enable.
 */
`timescale 1ns/1ps
`default_nettype none
module dual_slope_pwm_timer16
    import pwm16_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [2:0] clock_select_i,
    input wire logic [3:0] waveform_mode_bits_i,
    input wire logic [1:0] output_mode_bits_a_i,
    input wire logic [1:0] output_mode_bits_b_i,
    input wire logic [COUNT_W-1:0] write_data_i,
    input wire logic compare_a_wr_i,
    input wire logic compare_b_wr_i,
    input wire logic capture_top_wr_i,
    input wire logic overflow_clear_i,
    input wire logic compare_a_clear_i,
    input wire logic compare_b_clear_i,
    input wire logic capture_clear_i,
    input wire logic pin_direction_bit_a_i,
    input wire logic pin_direction_bit_b_i,
    input wire logic port_data_a_i,
    input wire logic port_data_b_i,
    output logic [COUNT_W-1:0] count_value_o,
    output logic [COUNT_W-1:0] capture_top_value_o,
    output logic count_up_o,
    output logic overflow_flag_o,
    output logic compare_a_flag_o,
    output logic compare_b_flag_o,
    output logic capture_flag_o,
    output logic compare_a_output_o,
    output logic compare_a_output_oe_o,
    output logic compare_b_output_o,
    output logic compare_b_output_oe_o
);
    logic [PRESCALE_W-1:0] div_q;
    logic [PRESCALE_W-1:0] div_limit;
    logic tick;
    logic dual_slope;
    logic phase_correct;
    logic top_is_capture;
    logic top_is_cmpa;
    logic fixed_top;
    logic [COUNT_W-1:0] top;
    logic [COUNT_W-1:0] wdata_masked;
    logic at_top;
    logic at_bottom;
    logic load;
    logic match_a;
    logic match_b;
    logic [COUNT_W-1:0] active_a;
    logic [COUNT_W-1:0] active_b;
    logic wave_a;
    logic wave_b;
    logic connect_a;
    logic connect_b;

    // -----------------------------------------------------------------
    // Prescaler: one-cycle timer tick
    // -----------------------------------------------------------------
    always_comb begin
        case (clock_select_i)
            PRESCALE_SEL_1: div_limit = DIV_1;
            PRESCALE_SEL_8: div_limit = DIV_8;
            PRESCALE_SEL_64: div_limit = DIV_64;
            PRESCALE_SEL_256: div_limit = DIV_256;
            PRESCALE_SEL_1024: div_limit = DIV_1024;
            default: div_limit = DIV_1;
        endcase
    end

    // Period = 2 x factor x top follows from one step per tick
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || clock_select_i == PRESCALE_STOP || div_q >= div_limit) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    // A stopped prescaler parks the divider, so a restart gives a full first step
    assign tick = (clock_select_i != PRESCALE_STOP) && (div_q >= div_limit);

    // -----------------------------------------------------------------
    // Mode decode and top select
    // -----------------------------------------------------------------
    always_comb begin
        phase_correct = 1'b0;
        dual_slope = 1'b1;
        top_is_capture = 1'b0;
        top_is_cmpa = 1'b0;
        fixed_top = 1'b1;
        top = TOP_8BIT;
        case (waveform_mode_bits_i)
            WAVE_PC8: begin
                phase_correct = 1'b1;
                top = TOP_8BIT;
            end
            WAVE_PC9: begin
                phase_correct = 1'b1;
                top = TOP_9BIT;
            end
            WAVE_PC10: begin
                phase_correct = 1'b1;
                top = TOP_10BIT;
            end
            WAVE_PC_CAP: begin
                phase_correct = 1'b1;
                top_is_capture = 1'b1;
                fixed_top = 1'b0;
                top = capture_top_value_o;
            end
            WAVE_PC_CMPA: begin
                phase_correct = 1'b1;
                top_is_cmpa = 1'b1;
                fixed_top = 1'b0;
                top = active_a;
            end
            WAVE_PFC_CAP: begin
                top_is_capture = 1'b1;
                fixed_top = 1'b0;
                top = capture_top_value_o;
            end
            WAVE_PFC_CMPA: begin
                top_is_cmpa = 1'b1;
                fixed_top = 1'b0;
                top = active_a;
            end
            default: begin
                dual_slope = 1'b0;
                fixed_top = 1'b0;
            end
        endcase
    end

    // Unused high bits are dropped at write time, not at compare time
    assign wdata_masked = fixed_top ? (write_data_i & top) : write_data_i;

    // Variable top is stored as written; below 0x0003 there is no useful PWM
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            capture_top_value_o <= COMPARE_RESET;
        end else if (capture_top_wr_i) begin
            capture_top_value_o <= write_data_i;
        end
    end

    // -----------------------------------------------------------------
    // Up/down counter
    // -----------------------------------------------------------------
    assign at_top = tick && dual_slope && count_up_o && (count_value_o == top);
    assign at_bottom = tick && dual_slope && !count_up_o && (count_value_o == COUNT_RESET);

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            count_value_o <= COUNT_RESET;
            count_up_o <= 1'b1;
        end else if (tick) begin
            if (!dual_slope) begin
                count_value_o <= COUNT_RESET;
                count_up_o <= 1'b1;
            end else if (count_up_o) begin
                if (count_value_o == top) begin
                    count_up_o <= 1'b0;
                    count_value_o <= count_value_o - 1'b1;
                end else begin
                    count_value_o <= count_value_o + 1'b1;
                end
            end else if (count_value_o == COUNT_RESET) begin
                count_up_o <= 1'b1;
                count_value_o <= count_value_o + 1'b1;
            end else begin
                count_value_o <= count_value_o - 1'b1;
            end
        end
    end

    // Outside the dual-slope modes compare writes go live at once
    assign load = !dual_slope || (phase_correct ? at_top : at_bottom);

    // -----------------------------------------------------------------
    // Compare channels
    // -----------------------------------------------------------------
    compare_channel #(
        .CAN_TOGGLE(1'b1)
    ) u_chan_a (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .tick_i(tick && dual_slope),
        .wr_i(compare_a_wr_i),
        .wdata_i(wdata_masked),
        .load_i(load),
        .count_i(count_value_o),
        .dir_up_i(count_up_o),
        .top_i(top),
        .mode_i(output_mode_bits_a_i),
        .wave_top_bit_i(waveform_mode_bits_i[WAVE_TOP_BIT]),
        .match_o(match_a),
        .active_o(active_a),
        .wave_o(wave_a)
    );

    compare_channel #(
        .CAN_TOGGLE(1'b0)
    ) u_chan_b (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .tick_i(tick && dual_slope),
        .wr_i(compare_b_wr_i),
        .wdata_i(wdata_masked),
        .load_i(load),
        .count_i(count_value_o),
        .dir_up_i(count_up_o),
        .top_i(top),
        .mode_i(output_mode_bits_b_i),
        .wave_top_bit_i(waveform_mode_bits_i[WAVE_TOP_BIT]),
        .match_o(match_b),
        .active_o(active_b),
        .wave_o(wave_b)
    );

    // -----------------------------------------------------------------
    // Event flags: a set in the clear cycle wins
    // -----------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            overflow_flag_o <= 1'b0;
        end else begin
            overflow_flag_o <= at_bottom
                || (overflow_flag_o && !overflow_clear_i);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            compare_a_flag_o <= 1'b0;
        end else begin
            compare_a_flag_o <= match_a || (at_top && top_is_cmpa)
                || (compare_a_flag_o && !compare_a_clear_i);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            compare_b_flag_o <= 1'b0;
        end else begin
            compare_b_flag_o <= match_b || (compare_b_flag_o && !compare_b_clear_i);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            capture_flag_o <= 1'b0;
        end else begin
            capture_flag_o <= (at_top && top_is_capture)
                || (capture_flag_o && !capture_clear_i);
        end
    end

    // -----------------------------------------------------------------
    // Pin muxing, registered so each pin follows the wave one clock later
    // -----------------------------------------------------------------
    assign connect_a = (output_mode_bits_a_i == OUT_NORMAL)
        || (output_mode_bits_a_i == OUT_INVERTED)
        || (output_mode_bits_a_i == OUT_TOGGLE && waveform_mode_bits_i[WAVE_TOP_BIT]);
    assign connect_b = (output_mode_bits_b_i == OUT_NORMAL)
        || (output_mode_bits_b_i == OUT_INVERTED);

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            compare_a_output_o <= 1'b0;
            compare_a_output_oe_o <= 1'b0;
        end else begin
            compare_a_output_o <= (connect_a && dual_slope) ? wave_a : port_data_a_i;
            compare_a_output_oe_o <= pin_direction_bit_a_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            compare_b_output_o <= 1'b0;
            compare_b_output_oe_o <= 1'b0;
        end else begin
            compare_b_output_o <= (connect_b && dual_slope) ? wave_b : port_data_b_i;
            compare_b_output_oe_o <= pin_direction_bit_b_i;
        end
    end

    // Channel B's live compare value is not needed at this level
    logic unused_b;
    assign unused_b = ^active_b;
endmodule
`default_nettype wire

// ---- pwm16_properties.sv ----
/*
 * Port checker for the dual-slope PWM timer.
 * Assumes it is bound to the timer top and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none
module pwm16_checker
    import pwm16_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [2:0] clock_select_i,
    input wire logic [3:0] waveform_mode_bits_i,
    input wire logic [1:0] output_mode_bits_a_i,
    input wire logic [1:0] output_mode_bits_b_i,
    input wire logic overflow_clear_i,
    input wire logic pin_direction_bit_a_i,
    input wire logic port_data_a_i,
    input wire logic [COUNT_W-1:0] count_value_o,
    input wire logic overflow_flag_o,
    input wire logic capture_flag_o,
    input wire logic compare_a_output_o,
    input wire logic compare_a_output_oe_o,
    input wire logic compare_b_output_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    // ----------------------------------------
    // Counter
    // ----------------------------------------
    a_stop_holds_count: assert property ((clock_select_i == PRESCALE_STOP
        && $past(clock_select_i) == PRESCALE_STOP && $stable(waveform_mode_bits_i))
        |=> $stable(count_value_o)) else $error("counter moved while stopped");
    a_fixed_top_bound: assert property ((waveform_mode_bits_i == WAVE_PC8
        && $past(waveform_mode_bits_i) == WAVE_PC8 && $past(count_value_o) <= TOP_8BIT)
        |-> count_value_o <= TOP_8BIT) else $error("count passed fixed top");
    a_top_one_tick: assert property ((waveform_mode_bits_i == WAVE_PC8
        && clock_select_i == PRESCALE_SEL_1 && $past(clock_select_i) == PRESCALE_SEL_1
        && $rose(count_value_o == TOP_8BIT)) |=> count_value_o == 16'h00FE)
        else $error("top not held for exactly one tick");
    a_bottom_turns_up: assert property ((waveform_mode_bits_i == WAVE_PC8
        && clock_select_i == PRESCALE_SEL_1 && $past(clock_select_i) == PRESCALE_SEL_1
        && $past(count_value_o) == 16'h0001 && count_value_o == 16'h0000)
        |=> count_value_o == 16'h0001) else $error("no turn at bottom");

    // ----------------------------------------
    // Flags and pins
    // ----------------------------------------
    a_overflow_at_bottom: assert property ((waveform_mode_bits_i == WAVE_PC8
        && $past(count_value_o) == 16'h0001 && count_value_o == 16'h0000)
        |-> ##[0:1] overflow_flag_o) else $error("overflow flag missing at bottom");
    a_overflow_sticky: assert property ((!$past(rst_i) && $past(overflow_flag_o)
        && !$past(overflow_clear_i)) |-> overflow_flag_o) else $error("flag dropped");
    a_disconnect_port: assert property ((!$past(rst_i)
        && output_mode_bits_a_i == OUT_DISCONNECT && $stable(port_data_a_i)
        && $past(output_mode_bits_a_i) == OUT_DISCONNECT)
        |-> compare_a_output_o == port_data_a_i) else $error("pin not port data");
    a_enable_follows_dir: assert property (!$past(rst_i)
        |-> compare_a_output_oe_o == $past(pin_direction_bit_a_i))
        else $error("enable not following direction");

    c_freq_overflow: cover property (waveform_mode_bits_i == WAVE_PFC_CMPA
        && $rose(overflow_flag_o));
    c_capture_top: cover property ($rose(capture_flag_o));
    c_inverted_high: cover property (output_mode_bits_b_i == OUT_INVERTED && compare_b_output_o);
endmodule

bind dual_slope_pwm_timer16 pwm16_checker chk (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .clock_select_i(clock_select_i),
    .waveform_mode_bits_i(waveform_mode_bits_i), .output_mode_bits_a_i(output_mode_bits_a_i),
    .output_mode_bits_b_i(output_mode_bits_b_i), .overflow_clear_i(overflow_clear_i),
    .pin_direction_bit_a_i(pin_direction_bit_a_i), .port_data_a_i(port_data_a_i),
    .count_value_o(count_value_o), .overflow_flag_o(overflow_flag_o),
    .capture_flag_o(capture_flag_o), .compare_a_output_o(compare_a_output_o),
    .compare_a_output_oe_o(compare_a_output_oe_o), .compare_b_output_o(compare_b_output_o)
);
`default_nettype wire

// ---- pwm_pin_load.sv ----
/*
 * Load on one waveform pin, with a pull-down.
 * Assumes value and output enable come straight from the timer.
 */
`timescale 1ns/1ps
`default_nettype none
module pwm_pin_load (
    input wire logic pin_value_i,
    input wire logic pin_oe_i,
    output logic pin_level_o
);
    // Released pin reads the pull-down, never the last driven value
    assign pin_level_o = pin_oe_i ? pin_value_i : 1'b0;
endmodule
`default_nettype wire

// ---- tb_dual_slope_pwm_timer16.sv ----
/*
 * Self-checking bench for the dual-slope PWM timer.
 * Assumes the checker is bound by its own file and pins end in pull-down loads.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_dual_slope_pwm_timer16;
    import pwm16_pkg::*;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [2:0] clock_select_i = 3'h0;
    logic [3:0] waveform_mode_bits_i = 4'h0;
    logic [1:0] output_mode_bits_a_i = 2'h0;
    logic [1:0] output_mode_bits_b_i = 2'h0;
    logic [15:0] write_data_i = 16'h0000;
    logic compare_a_wr_i = 1'b0;
    logic compare_b_wr_i = 1'b0;
    logic capture_top_wr_i = 1'b0;
    logic overflow_clear_i = 1'b0;
    logic compare_a_clear_i = 1'b0;
    logic compare_b_clear_i = 1'b0;
    logic capture_clear_i = 1'b0;
    logic pin_direction_bit_a_i = 1'b0;
    logic pin_direction_bit_b_i = 1'b0;
    logic port_data_a_i = 1'b0;
    logic port_data_b_i = 1'b0;
    wire logic [15:0] count_value_o, capture_top_value_o;
    wire logic count_up_o, overflow_flag_o, compare_a_flag_o, compare_b_flag_o, capture_flag_o;
    wire logic compare_a_output_o, compare_a_output_oe_o, compare_b_output_o;
    wire logic compare_b_output_oe_o, pin_a, pin_b;
    wire logic [3:0] flags;
    int errors = 0;
    int check_count = 0;
    int r;

    assign flags = {capture_flag_o, compare_b_flag_o, compare_a_flag_o, overflow_flag_o};
    always #10 ref_clk_i = ~ref_clk_i;

    dual_slope_pwm_timer16 dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .clock_select_i(clock_select_i), .waveform_mode_bits_i(waveform_mode_bits_i),
        .output_mode_bits_a_i(output_mode_bits_a_i), .output_mode_bits_b_i(output_mode_bits_b_i),
        .write_data_i(write_data_i), .compare_a_wr_i(compare_a_wr_i),
        .compare_b_wr_i(compare_b_wr_i), .capture_top_wr_i(capture_top_wr_i),
        .overflow_clear_i(overflow_clear_i), .compare_a_clear_i(compare_a_clear_i),
        .compare_b_clear_i(compare_b_clear_i), .capture_clear_i(capture_clear_i),
        .pin_direction_bit_a_i(pin_direction_bit_a_i),
        .pin_direction_bit_b_i(pin_direction_bit_b_i), .port_data_a_i(port_data_a_i),
        .port_data_b_i(port_data_b_i), .count_value_o(count_value_o),
        .capture_top_value_o(capture_top_value_o), .count_up_o(count_up_o),
        .overflow_flag_o(overflow_flag_o), .compare_a_flag_o(compare_a_flag_o),
        .compare_b_flag_o(compare_b_flag_o), .capture_flag_o(capture_flag_o),
        .compare_a_output_o(compare_a_output_o), .compare_a_output_oe_o(compare_a_output_oe_o),
        .compare_b_output_o(compare_b_output_o), .compare_b_output_oe_o(compare_b_output_oe_o));
    pwm_pin_load load_a (.pin_value_i(compare_a_output_o), .pin_oe_i(compare_a_output_oe_o),
        .pin_level_o(pin_a));
    pwm_pin_load load_b (.pin_value_i(compare_b_output_o), .pin_oe_i(compare_b_output_oe_o),
        .pin_level_o(pin_b));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [2:0] sel, input logic [15:0] v);
        write_data_i = v;
        {capture_top_wr_i, compare_b_wr_i, compare_a_wr_i} = sel;
        @(posedge ref_clk_i);
        #1;
        {capture_top_wr_i, compare_b_wr_i, compare_a_wr_i} = 3'h0;
        // Spare edge so a following write never re-raises a strobe in the same step
        @(posedge ref_clk_i);
        #1;
    endtask

    // Compare values exceed top only with a fixed top, which masks them on write, so every channel keeps matching
    task automatic load_values(input int top, input int cmp, input logic atop);
        wr(3'h4, 16'(top));
        wr(3'h1, atop ? 16'(top) : 16'(cmp));
        wr(3'h2, 16'(cmp));
    endtask

    // After a spare edge clears all flags, then counts edges until flag f is set again
    task automatic wait_flag(input int f, output int n);
        n = 0;
        @(posedge ref_clk_i);
        #1;
        {capture_clear_i, compare_b_clear_i, compare_a_clear_i, overflow_clear_i} = 4'hF;
        do begin
            @(posedge ref_clk_i);
            #1;
            {capture_clear_i, compare_b_clear_i, compare_a_clear_i, overflow_clear_i} = 4'h0;
            n++;
        end while (flags[f] !== 1'b1 && n < 40000);
    endtask

    function automatic int exp_high(input logic [1:0] om, input int top, input int cmp);
        return (om == OUT_NORMAL) ? 2 * cmp : 2 * (top - cmp);
    endfunction

    // Top stays fixed while running, so either dual-slope family fits
    task automatic run(input logic [3:0] mode, input logic [2:0] cs, input int scale,
                       input logic [1:0] om, input int top, input int cmp);
        int n;
        int per;
        int hia;
        int hib;
        int live;
        logic atop;
        atop = (mode == WAVE_PFC_CMPA || mode == WAVE_PC_CMPA);
        live = (mode[WAVE_TOP_BIT] == 1'b0) ? (cmp & top) : cmp;
        per = 2 * top * scale;
        hia = 0;
        hib = 0;
        rst_i = 1'b1;
        waveform_mode_bits_i = 4'h0;
        clock_select_i = PRESCALE_STOP;
        {output_mode_bits_a_i, output_mode_bits_b_i} = 4'h0;
        {port_data_a_i, port_data_b_i} = 2'($urandom_range(3, 0));
        repeat (2) @(posedge ref_clk_i);
        #1;
        rst_i = 1'b0;
        {pin_direction_bit_a_i, pin_direction_bit_b_i} = 2'h3;
        load_values(top, cmp, atop);
        check("capture_top", 32'(top), 32'(capture_top_value_o));
        check("pin_a_port", 32'(port_data_a_i), 32'(pin_a));
        // Compare A equal to top toggles once a period: high for half of it
        {output_mode_bits_a_i, output_mode_bits_b_i} = {atop ? OUT_TOGGLE : om, om};
        waveform_mode_bits_i = mode;
        clock_select_i = cs;
        load_values(top, cmp, atop);
        wait_flag(0, n);
        wait_flag(0, n);
        check("period", 32'(per), 32'(n + 1));
        check("turn_at_bottom", 32'h00010001, 32'({count_up_o, count_value_o}));
        repeat (per) begin
            @(posedge ref_clk_i);
            #1;
            hia += int'(pin_a);
            hib += int'(pin_b);
        end
        check("high_b", 32'(exp_high(om, top, live) * scale), 32'(hib));
        check("high_a", 32'((atop ? top : exp_high(om, top, live)) * scale),
            32'(hia));
        wait_flag(2, n);
        check("match_flag_b", 32'h1, 32'(n <= per));
        if (mode[WAVE_TOP_BIT]) begin
            wait_flag(atop ? 1 : 3, n);
            check("top_flag", 32'h1, 32'(n <= per));
        end
        pin_direction_bit_b_i = 1'b0;
        repeat (2) @(posedge ref_clk_i);
        #1;
        check("pin_b_released", 32'h0, {30'h0, compare_b_output_oe_o, pin_b});
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        r = $urandom(32'h0EB84346);
        repeat (10) @(posedge ref_clk_i);
        #1;
        run(WAVE_PC8, PRESCALE_SEL_1, 1, OUT_NORMAL, TOP_8BIT,
            $urandom_range(254, 1));
        run(WAVE_PC9, PRESCALE_SEL_1, 1, OUT_INVERTED, TOP_9BIT,
            32'hFE00 | $urandom_range(511, 0));
        run(WAVE_PC10, PRESCALE_SEL_1, 1, OUT_NORMAL, TOP_10BIT, TOP_10BIT);
        r = $urandom_range(200, 3);
        run(WAVE_PC_CAP, PRESCALE_SEL_1, 1, OUT_NORMAL, r, 0);
        r = $urandom_range(200, 3);
        run(WAVE_PC_CMPA, PRESCALE_SEL_1, 1, OUT_INVERTED, r, $urandom_range(r, 0));
        run(WAVE_PFC_CAP, PRESCALE_SEL_1, 1, OUT_INVERTED, TOP_MIN_VARIABLE, 0);
        r = $urandom_range(60, 3);
        run(WAVE_PFC_CMPA, PRESCALE_SEL_8, 8, OUT_NORMAL, r, r);
        run(WAVE_PFC_CAP, PRESCALE_SEL_64, 64, OUT_NORMAL, 3, 2);
        run(WAVE_PC_CAP, PRESCALE_SEL_256, 256, OUT_INVERTED, 3, 1);
        run(WAVE_PFC_CMPA, PRESCALE_SEL_1024, 1024, OUT_NORMAL, 3, 1);
        finish_test();
    end

    initial begin
        #2000000;
        errors++;
        finish_test();
    end
endmodule
`default_nettype wire
